// *** reload_timer_pkg.sv ***
/*
  package for the eight-bit reload timer with pulse output: register map,
  field positions, reset values, prescale counts.
  assumes an apb slave at 32-bit data, one register per aligned word.
*/
// Notes on behaviour
// [R1] the timer is an 8-bit down counter with an 8-bit reload latch.
// [R2] with write_latch_only at 1 a timer write goes only to the latch, which loads at underflow.
// [R3] with write_latch_only at 0 a timer write loads counter and latch together.
// [R4] reset clears write_latch_only so writes go to both counter and latch.
// [R5] each underflow sets the interrupt request, reloads from the latch and keeps counting.
// [R6] the count clock is core clock divided by 8 or sub_clock_input divided by 2, per timer_clock_sel.
// [R7] pulse_out_source_sel at 0 routes this timer to the pin, at 1 the second timer.
// [R8] pulse_out_polarity at 1 starts the pin low, at 0 starts it high.
// [R9] pulse_out_enable at 1 enables the pin driver, at 0 disables it.
// [R10] software enters pulse output mode with enable 1 and source 0; the pin then follows this timer.
// [R11] in pulse output mode each underflow toggles the pin and sets the request: 50 percent duty.
// [R12] with enable 1 and source 1 the pin toggles on second timer underflows instead.
// [R13] timer_stop_bit at 0 lets the timer count, at 1 freezes it.
package reload_timer_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [11:0] mode_ctrl_addr   = 12'h000;
  localparam logic [11:0] timer_data_addr  = 12'h004;
  localparam logic [11:0] irq_status_addr  = 12'h008;
  localparam logic [11:0] irq_enable_addr  = 12'h00C;
  localparam logic [11:0] irq_clear_addr   = 12'h010;

  ////////////////////////////////////////////////////////////////////////////
  // mode register fields
  localparam int pulse_out_source_sel  = 0;
  localparam int timer_stop_bit        = 1;
  localparam int timer_clock_sel       = 2;
  localparam int second_timer_clock_sel = 3;
  localparam int third_timer_clock_sel = 4;
  localparam int pulse_out_polarity    = 5;
  localparam int pulse_out_enable      = 6;
  localparam int write_latch_only      = 7;

  // interrupt status fields
  localparam int irq_timer_bit  = 0;
  localparam int irq_second_bit = 1;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] mode_reset  = 8'h00;
  localparam logic [7:0] count_reset = 8'hFF;
  localparam logic [7:0] latch_reset = 8'hFF;

  // prescale counts
  localparam int core_div   = 8;
  localparam int sub_div    = 2;
  localparam int core_div_w = $clog2(core_div);

endpackage

// *** reload_timer.sv ***
/*
  eight-bit reload timer with square-wave pulse output and apb register file.
  assumes sub_clock_input and second_timer_underflow are synchronous to
  core_clk; the second timer itself lives outside this block.
*/
module reload_timer
  import reload_timer_pkg::*;
#(
  parameter int data_w = 8
)
(
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // companion and clock sources
  input  wire logic              sub_clock_input,
  input  wire logic              second_timer_underflow,
  // pulse pin and interrupt
  output logic                   pulse_out_pin,
  output logic                   pulse_out_pin_oe,
  output logic                   timer_underflow,
  output logic                   irq
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [7:0]            mode_reg;
  logic [data_w-1:0]     count;
  logic [data_w-1:0]     latch;
  logic [core_div_w-1:0] prescale;
  logic                  sub_prev;
  logic                  sub_phase;
  logic                  pin_level;
  logic [1:0]            irq_status;
  logic [1:0]            irq_enable;
  logic [31:0]           rdata;

  logic [7:0]            next_mode_reg;
  logic [data_w-1:0]     next_count;
  logic [data_w-1:0]     next_latch;
  logic [core_div_w-1:0] next_prescale;
  logic                  next_sub_phase;
  logic                  next_pin_level;
  logic [1:0]            next_irq_status;
  logic [1:0]            next_irq_enable;
  logic [31:0]           next_rdata;

  logic                  wr_en;
  logic                  rd_en;
  logic                  tick;
  logic                  underflow;
  logic                  mapped;
  logic                  toggle_src;
  logic                  pulse_active;

  // register hit test, used for decode and error answer
  function automatic logic hit(input logic [11:0] a, input logic [11:0] reg_addr);
    hit = (a == reg_addr);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bus decode: one-cycle access phase, zero wait states
  always_comb
  begin
    mapped  = hit(paddr, mode_ctrl_addr) || hit(paddr, timer_data_addr) ||
              hit(paddr, irq_status_addr) || hit(paddr, irq_enable_addr) ||
              hit(paddr, irq_clear_addr);
    wr_en   = psel && penable && pwrite && mapped;
    rd_en   = psel && !penable && !pwrite;
    pready  = 1'b1;
    pslverr = psel && penable && !mapped;
  end

  ////////////////////////////////////////////////////////////////////////////
  // count clock: core/8 or sub clock rising edges /2
  always_comb
  begin
    next_prescale  = prescale + 1'b1; // wraps every core_div cycles
    next_sub_phase = sub_phase;
    if (mode_reg[timer_clock_sel])
    begin
      tick = 1'b0;
      if (sub_clock_input && !sub_prev)
      begin
        next_sub_phase = !sub_phase;
        tick           = sub_phase; // every second rising edge, see [R6]
      end
    end
    else
    begin
      tick = (prescale == core_div_w'(core_div - 1)); // see [R6]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter, latch and mode register
  always_comb
  begin
    next_mode_reg = mode_reg;
    next_count    = count;
    next_latch    = latch;
    underflow     = 1'b0;
    if (tick && !mode_reg[timer_stop_bit]) // see [R13]
    begin
      if (count == '0)
      begin
        underflow  = 1'b1;
        next_count = latch; // reload and keep counting, see [R5] [R1]
      end
      else
      begin
        next_count = count - 1'b1; // see [R1]
      end
    end
    if (wr_en && hit(paddr, mode_ctrl_addr))
    begin
      next_mode_reg = pwdata[7:0];
    end
    if (wr_en && hit(paddr, timer_data_addr))
    begin
      next_latch = pwdata[data_w-1:0]; // see [R2] [R3]
      if (!mode_reg[write_latch_only])
      begin
        next_count = pwdata[data_w-1:0]; // write wins over a same-cycle reload, see [R3]
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      mode_reg  <= mode_reset; // write_latch_only cleared, see [R4]
      count     <= count_reset;
      latch     <= latch_reset;
      prescale  <= '0;
      sub_prev  <= 1'b0;
      sub_phase <= 1'b0;
    end
    else
    begin
      mode_reg  <= next_mode_reg;
      count     <= next_count;
      latch     <= next_latch;
      prescale  <= next_prescale;
      sub_prev  <= sub_clock_input;
      sub_phase <= next_sub_phase;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pulse pin: starts at polarity level while disabled, toggles when enabled
  always_comb
  begin
    pulse_active = mode_reg[pulse_out_enable]; // see [R9] [R10]
    toggle_src   = mode_reg[pulse_out_source_sel] ? second_timer_underflow // see [R12]
                                                  : underflow;             // see [R7]
    if (!pulse_active)
    begin
      next_pin_level = !mode_reg[pulse_out_polarity]; // 1 starts low, see [R8]
    end
    else if (toggle_src)
    begin
      next_pin_level = !pin_level; // 50 percent square wave, see [R11]
    end
    else
    begin
      next_pin_level = pin_level;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      pin_level <= 1'b1;
    end
    else
    begin
      pin_level <= next_pin_level;
    end
  end

  // pin driven only when enabled; polarity change while running is not re-applied
  assign pulse_out_pin    = pin_level;
  assign pulse_out_pin_oe = mode_reg[pulse_out_enable]; // see [R9]

  ////////////////////////////////////////////////////////////////////////////
  // interrupts: set wins over a same-cycle clear
  always_comb
  begin
    next_irq_enable = irq_enable;
    next_irq_status = irq_status;
    if (wr_en && hit(paddr, irq_enable_addr))
    begin
      next_irq_enable = pwdata[1:0];
    end
    if (wr_en && hit(paddr, irq_clear_addr))
    begin
      next_irq_status = irq_status & ~pwdata[1:0];
    end
    if (underflow)
    begin
      next_irq_status[irq_timer_bit] = 1'b1; // see [R5] [R11]
    end
    if (second_timer_underflow)
    begin
      next_irq_status[irq_second_bit] = 1'b1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      irq_status <= 2'b00;
      irq_enable <= 2'b00;
    end
    else
    begin
      irq_status <= next_irq_status;
      irq_enable <= next_irq_enable;
    end
  end

  assign irq             = |(irq_status & irq_enable);
  assign timer_underflow = underflow;

  ////////////////////////////////////////////////////////////////////////////
  // read data captured in setup so it stands through the access phase
  always_comb
  begin
    next_rdata = rdata;
    if (rd_en)
    begin
      next_rdata = 32'h0000_0000;
      if (hit(paddr, mode_ctrl_addr))
      begin
        next_rdata[7:0] = mode_reg;
      end
      else if (hit(paddr, timer_data_addr))
      begin
        next_rdata[data_w-1:0] = count;
      end
      else if (hit(paddr, irq_status_addr))
      begin
        next_rdata[1:0] = irq_status;
      end
      else if (hit(paddr, irq_enable_addr))
      begin
        next_rdata[1:0] = irq_enable;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      rdata <= 32'h0000_0000;
    end
    else
    begin
      rdata <= next_rdata;
    end
  end

  assign prdata = rdata;

endmodule

// *** reload_timer_checker.sv ***
/* checker for the reload timer: pin toggling, irq cause, count spacing.
   assumes a bind onto the reload_timer ports, one core clock domain. */
module reload_timer_checker (
  // clock, reset, apb
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // timer side
  input wire logic        second_timer_underflow,
  input wire logic        pulse_out_pin,
  input wire logic        pulse_out_pin_oe,
  input wire logic        timer_underflow,
  input wire logic        irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [7:0] md;
  logic       wr;
  logic       uf;
  //////////////////////////////////////////////////////////////////////////
  // mode shadow, taken at the same access edge as the design
  assign wr = psel && penable && pwrite;
  assign uf = timer_underflow || second_timer_underflow;
  always_ff @(posedge core_clk)
    if (rst)
      md <= 8'h00;
    else if (wr && paddr == 12'h000)
      md <= pwdata[7:0];
  //////////////////////////////////////////////////////////////////////////
  property p_own_tgl;
    timer_underflow && pulse_out_pin_oe && !md[0] |=> pulse_out_pin != $past(pulse_out_pin);
  endproperty
  a_own_tgl: assert property (p_own_tgl) else $error("pin missed own toggle");
  property p_sec_tgl;
    second_timer_underflow && pulse_out_pin_oe && md[0] |=> $changed(pulse_out_pin);
  endproperty
  a_sec_tgl: assert property (p_sec_tgl) else $error("pin missed second toggle");
  property p_oe;
    pulse_out_pin_oe == md[6];
  endproperty
  a_oe: assert property (p_oe) else $error("pin enable wrong");
  property p_idle;
    !pulse_out_pin_oe && $past(!pulse_out_pin_oe) && $stable(md[5]) |-> pulse_out_pin == !md[5];
  endproperty
  a_idle: assert property (p_idle) else $error("start level wrong");
  property p_stop;
    md[1] && $past(md[1]) |-> !timer_underflow;
  endproperty
  a_stop: assert property (p_stop) else $error("underflow while stopped");
  property p_space;
    timer_underflow && !md[2] |=> !timer_underflow [*7];
  endproperty
  a_space: assert property (p_space) else $error("ticks closer than eight");
  property p_irq;
    $rose(irq) |-> $past(uf || wr);
  endproperty
  a_irq: assert property (p_irq) else $error("irq without cause");
  property p_pin;
    $changed(pulse_out_pin) && pulse_out_pin_oe && $past(pulse_out_pin_oe) |-> $past(uf);
  endproperty
  a_pin: assert property (p_pin) else $error("pin moved without underflow");
  // main scenarios reached
  c_tgl: cover property (timer_underflow && pulse_out_pin_oe);
  c_sec: cover property (second_timer_underflow && md[0]);
  c_irq: cover property ($rose(irq));
endmodule

// *** reload_timer_tb_top.sv ***
/* bench for the reload timer: apb tasks and directed timer scenarios.
   assumes the package, design and checker are compiled first. */
module reload_timer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk, rst, psel, penable, pwrite, serr, sub_run;
  logic        sub_clock_input, second_timer_underflow, pready, pslverr;
  logic        pulse_out_pin, pulse_out_pin_oe, timer_underflow, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  int          err_total, check_count, n;
  reload_timer DUT (
    .core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .sub_clock_input, .second_timer_underflow, .pulse_out_pin,
    .pulse_out_pin_oe, .timer_underflow, .irq
  );
  //////////////////////////////////////////////////////////////////////////
  // 200 MHz core clock
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // sub clock rises every two cycles, so one tick every four
  // one driver only: held low until sub_run, then toggles every edge
  always @(posedge core_clk)
    sub_clock_input <= sub_run && !sub_clock_input;
  //////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // a used-up wait counts as a mismatch
  task automatic tmo();
    err_total++;
    $display("BAD %0t wait ran out", $time);
    stop_test();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer; request held until pready is seen
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge core_clk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50)
      tmo();
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  // edges up to the next underflow, checked when e is above zero
  task automatic gap(input int e);
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (timer_underflow !== 1'b1 && n < 3000);
    if (n >= 3000)
      tmo();
    if (e > 0)
      chk(32'(n), 32'(e));
  endtask
  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    {rst, psel, penable, pwrite, sub_run} = 5'b10000;
    {paddr, pwdata, second_timer_underflow} = '0;
    err_total = 0;
    check_count = 0;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    chk({pulse_out_pin, pulse_out_pin_oe, irq}, 3'b100);
    rd(12'h000, 32'h0);
    rd(12'h004, 32'hFF);
    rd(12'h014, 32'h0);
    chk(serr, 1'b1);
    // unmapped write is refused and leaves the mode alone
    wr(12'h014, 32'hFF);
    chk(serr, 1'b1);
    rd(12'h000, 32'h0);
    rd(12'h010, 32'h0);
    // direct load, period and interrupt
    wr(12'h00C, 32'h1);
    rd(12'h00C, 32'h1);
    wr(12'h004, 32'h3);
    xfer(1'b0, 12'h004, 32'h0);
    chk(rdat <= 32'h3, 1'b1);
    gap(0);
    gap(32);
    @(posedge core_clk);
    chk(irq, 1'b1);
    rd(12'h008, 32'h1);
    wr(12'h010, 32'h1);
    @(posedge core_clk);
    chk(irq, 1'b0);
    gap(0);
    wr(12'h00C, 32'h0);
    @(posedge core_clk);
    chk(irq, 1'b0);
    rd(12'h008, 32'h1);
    wr(12'h010, 32'h1);
    wr(12'h00C, 32'h1);
    // latch only: counter untouched now, new value enters at the next underflow
    wr(12'h000, 32'h80);
    wr(12'h004, 32'h5);
    rd(12'h004, 32'h1);
    gap(0);
    gap(48);
    // own pulse output, start high, equal halves
    wr(12'h000, 32'hC0);
    @(posedge core_clk);
    chk(pulse_out_pin, 1'b1);
    gap(0);
    @(posedge core_clk);
    chk(pulse_out_pin, 1'b0);
    gap(47);
    @(posedge core_clk);
    chk(pulse_out_pin, 1'b1);
    // polarity one starts low, then second timer drives the pin
    wr(12'h000, 32'h20);
    repeat (2) @(posedge core_clk);
    chk({pulse_out_pin_oe, pulse_out_pin}, 2'b00);
    wr(12'h000, 32'h61);
    @(posedge core_clk);
    chk({pulse_out_pin_oe, pulse_out_pin}, 2'b10);
    rd(12'h000, 32'h61);
    second_timer_underflow <= 1'b1;
    @(posedge core_clk);
    second_timer_underflow <= 1'b0;
    @(posedge core_clk);
    chk(pulse_out_pin, 1'b1);
    gap(0);
    @(posedge core_clk);
    chk(pulse_out_pin, 1'b1);
    rd(12'h008, 32'h3);
    // sub clock source, then stop right after a reload
    wr(12'h000, 32'h04);
    wr(12'h004, 32'h3);
    sub_run <= 1'b1;
    gap(0);
    gap(16);
    wr(12'h000, 32'h06);
    rd(12'h004, 32'h3);
    repeat (40) @(posedge core_clk);
    rd(12'h004, 32'h3);
    stop_test();
  end
endmodule

bind reload_timer reload_timer_checker chk_i (
  .core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .second_timer_underflow,
  .pulse_out_pin, .pulse_out_pin_oe, .timer_underflow, .irq
);
